// >>> common/gwoc_pkg.sv
// constants and types shared by the gauge wake and calibration block
package gwoc_pkg;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_FMIN = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_ICLR = 8'h14;
    localparam logic [7:0] A_IEN = 8'h18;
    localparam logic [7:0] A_RDATA = 8'h1C;
    localparam logic [7:0] A_SADDR = 8'h20;
    localparam logic [7:0] A_SDATA = 8'h24;
    localparam logic [7:0] A_OFFS = 8'h28;
    localparam logic [7:0] A_CORR = 8'h2C;
    localparam logic [7:0] A_CHG = 8'h30;
    // control register fields
    localparam int B_RANGE = 0;
    localparam int B_SLO = 1;
    localparam int B_SHI = 2;
    // command register subcommands, reset type in bits 9:8
    localparam logic [7:0] SC_RESET = 8'h01;
    localparam logic [7:0] SC_RQUERY = 8'h02;
    localparam logic [7:0] SC_IDLE = 8'h03;
    localparam logic [7:0] SC_DEEP = 8'h04;
    localparam logic [7:0] SC_DORM = 8'h05;
    localparam logic [7:0] SC_WAKE = 8'h06;
    localparam int B_RTYPE = 8;
    // interrupt status bits
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_CALD = 1;
    localparam int IRQ_ABRT = 2;
    localparam int IRQ_REFUSE = 3;
    localparam int NIRQ = 4;
    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] FMIN_RST = 16'h0D48;
    // wake thresholds in microvolts
    localparam logic [15:0] THR_1 = 16'd1000;
    localparam logic [15:0] THR_2 = 16'd2200;
    localparam logic [15:0] THR_4 = 16'd4600;
    localparam logic [15:0] THR_9 = 16'd9800;
    // calibration limits
    localparam logic signed [7:0] CAL_T_LO = 8'sd5;
    localparam logic signed [7:0] CAL_T_HI = 8'sd45;
    localparam logic [16:0] CAL_I_MAX = 17'd100;
    localparam logic [16:0] CAL_DV = 17'd256;
    localparam logic [16:0] CAL_DT = 17'd8;
    localparam logic [16:0] ABORT_DV = 17'd32;
    localparam logic [16:0] IDLE_I_MAX = 17'd10;
    // timing
    localparam longint CLK_HZ = 50_000_000;
    localparam longint DRIFT_S = 60;
    localparam longint DOZE_MS = 10;
    localparam longint DRIFT_CYC = DRIFT_S * CLK_HZ;
    localparam longint DOZE_CYC = DOZE_MS * CLK_HZ / 1000;
    // power modes, gray along normal-idle-deep-dormant
    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_IDLE = 2'b01,
        PM_DEEP = 2'b11,
        PM_DORM = 2'b10
    } gwoc_pm_e;
endpackage: gwoc_pkg

// >>> common/gwoc_wake_if.sv
// link between the control core and the wake comparator
`timescale 1ns/10ps
interface gwoc_wake_if;
    logic range_sel;
    logic sel_hi;
    logic sel_lo;
    logic armed;
    logic signed [15:0] sense_uv;
    logic wake;
    modport ctl(output range_sel, sel_hi, sel_lo, armed, sense_uv,
        input wake);
    modport cmp(input range_sel, sel_hi, sel_lo, armed, sense_uv,
        output wake);
endinterface: gwoc_wake_if

// >>> hdl/gwoc_top.sv
// gauge control core: power modes, offset calibration, store, counters
`timescale 1ns/10ps
module gwoc_top #(
    parameter longint DRIFT_CYCLES = gwoc_pkg::DRIFT_CYC, // drift hold
    parameter longint DOZE_CYCLES = gwoc_pkg::DOZE_CYC // idle to deep
) (
    input wire logic mclk, // core clock, 50 MHz
    input wire logic rst, // synchronous reset, high
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire logic meas_valid, // new measurement set pulse
    input wire logic signed [15:0] sense_uv, // raw sense voltage, uV
    input wire logic [15:0] cell_mv, // cell voltage, mV
    input wire logic signed [7:0] temp_c, // temperature, degrees C
    input wire logic signed [15:0] mean_ma, // mean cell current, mA
    input wire logic cal_done, // offset measurement finished
    input wire logic signed [15:0] cal_offset, // measured offset, uV
    output logic cal_start, // one cycle calibration start
    output logic [1:0] power_mode, // present power mode
    output logic irq // level interrupt
);
    initial begin
        if (DRIFT_CYCLES < 1 || DRIFT_CYCLES > 64'hFFFF_FFFF
            || DOZE_CYCLES < 1 || DOZE_CYCLES > 64'hFFFF_FFFF)
            $error("gwoc_top: cycle counts out of range");
    end

    localparam logic [31:0] DRIFT_N = 32'(DRIFT_CYCLES);
    localparam logic [31:0] DOZE_N = 32'(DOZE_CYCLES);

    // magnitude of a signed difference
    function automatic logic [16:0] mag(input logic signed [16:0] v);
        mag = v[16] ? 17'(-v) : 17'(v);
    endfunction: mag

    gwoc_pkg::gwoc_pm_e pm;
    gwoc_pkg::gwoc_pm_e next_pm;
    logic [2:0] ctrl;
    logic [15:0] flash_min;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [31:0] rst_cnt;
    logic [31:0] rst_snap;
    logic [5:0] st_addr;
    logic [7:0] store [64];
    logic cal_busy;
    logic [15:0] cal_v0;
    logic [15:0] last_v;
    logic signed [7:0] last_t;
    logic [31:0] drift_cnt;
    logic [31:0] doze_cnt;
    logic signed [15:0] offset;
    logic signed [15:0] sense_corr;
    logic signed [31:0] charge;
    logic [31:0] next_rdata;

    gwoc_wake_if wif();

    // wake comparator sees configuration and the raw sense voltage
    assign wif.range_sel = ctrl[gwoc_pkg::B_RANGE];
    assign wif.sel_hi = ctrl[gwoc_pkg::B_SHI];
    assign wif.sel_lo = ctrl[gwoc_pkg::B_SLO];
    assign wif.armed = (pm == gwoc_pkg::PM_IDLE)
        || (pm == gwoc_pkg::PM_DEEP);
    assign wif.sense_uv = sense_uv;

    gwoc_wake u_wake (
        .mclk(mclk),
        .rst(rst),
        .w(wif.cmp)
    );

    // register decode
    wire logic [7:0] subcmd = wdata[7:0];
    wire logic wr_cmd = wr && (addr == gwoc_pkg::A_CMD);
    wire logic cmd_reset = wr_cmd && (subcmd == gwoc_pkg::SC_RESET);
    wire logic cmd_query = wr_cmd && (subcmd == gwoc_pkg::SC_RQUERY);
    wire logic cmd_idle = wr_cmd && (subcmd == gwoc_pkg::SC_IDLE);
    wire logic cmd_deep = wr_cmd && (subcmd == gwoc_pkg::SC_DEEP);
    wire logic cmd_dorm = wr_cmd && (subcmd == gwoc_pkg::SC_DORM);
    wire logic cmd_wake = wr_cmd && (subcmd == gwoc_pkg::SC_WAKE);
    wire logic [1:0] rtype = wdata[gwoc_pkg::B_RTYPE +: 2];
    wire logic wr_sdata = wr && (addr == gwoc_pkg::A_SDATA);
    wire logic flash_ok = cell_mv >= flash_min;
    wire logic refuse = wr_sdata && !flash_ok;

    // calibration conditions
    wire logic temp_ok = (temp_c > gwoc_pkg::CAL_T_LO)
        && (temp_c < gwoc_pkg::CAL_T_HI);
    wire logic cur_ok = mag(17'(mean_ma)) <= gwoc_pkg::CAL_I_MAX;
    wire logic [16:0] dv = mag($signed({1'b0, cell_mv})
        - $signed({1'b0, last_v}));
    wire logic [16:0] dt = mag(17'(temp_c) - 17'(last_t));
    wire logic v_dev = dv >= gwoc_pkg::CAL_DV;
    wire logic t_dev = dt > gwoc_pkg::CAL_DT;
    wire logic t_long = drift_cnt >= DRIFT_N;
    wire logic enter_idle = (pm == gwoc_pkg::PM_NORMAL)
        && (next_pm == gwoc_pkg::PM_IDLE);
    wire logic cal_go = !cal_busy && ((enter_idle && temp_ok)
        || (cur_ok && (v_dev || t_long)));
    wire logic [16:0] drop = 17'($signed({1'b0, cal_v0})
        - $signed({1'b0, cell_mv}));
    wire logic abort = cal_busy && meas_valid && !drop[16]
        && (drop > gwoc_pkg::ABORT_DV);
    wire logic idle_i = mag(17'(mean_ma)) <= gwoc_pkg::IDLE_I_MAX;
    wire logic [3:0] events = {refuse, abort,
        cal_busy && cal_done && !abort, wif.wake};

    // power mode sequencing: events and commands
    always_comb begin
        next_pm = pm;
        case (pm)
            gwoc_pkg::PM_NORMAL: begin
                if (cmd_dorm) next_pm = gwoc_pkg::PM_DORM;
                else if (cmd_deep) next_pm = gwoc_pkg::PM_DEEP;
                else if (cmd_idle || (meas_valid && idle_i))
                    next_pm = gwoc_pkg::PM_IDLE;
            end
            gwoc_pkg::PM_IDLE: begin
                if (wif.wake || cmd_wake) next_pm = gwoc_pkg::PM_NORMAL;
                else if (cmd_dorm) next_pm = gwoc_pkg::PM_DORM;
                else if (cmd_deep || doze_cnt >= DOZE_N)
                    next_pm = gwoc_pkg::PM_DEEP;
            end
            gwoc_pkg::PM_DEEP: begin
                if (wif.wake || cmd_wake) next_pm = gwoc_pkg::PM_NORMAL;
                else if (cmd_dorm) next_pm = gwoc_pkg::PM_DORM;
            end
            gwoc_pkg::PM_DORM: begin
                if (cmd_wake) next_pm = gwoc_pkg::PM_NORMAL;
            end
            default: next_pm = gwoc_pkg::PM_NORMAL;
        endcase
        if (cmd_reset) next_pm = gwoc_pkg::PM_NORMAL;
    end

    // power mode and idle dwell counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            pm <= gwoc_pkg::PM_NORMAL;
            doze_cnt <= 32'h0000_0000;
        end else begin
            pm <= next_pm;
            doze_cnt <= (next_pm == gwoc_pkg::PM_IDLE && pm == next_pm)
                ? doze_cnt + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    // configuration registers, written by software
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= gwoc_pkg::CTRL_RST;
            flash_min <= gwoc_pkg::FMIN_RST;
            irq_en <= 4'h0;
            st_addr <= 6'h00;
        end else if (wr) begin
            case (addr)
                gwoc_pkg::A_CTRL: ctrl <= wdata[2:0];
                gwoc_pkg::A_FMIN: flash_min <= wdata[15:0];
                gwoc_pkg::A_IEN: irq_en <= wdata[3:0];
                gwoc_pkg::A_SADDR: st_addr <= wdata[5:0];
                default: ;
            endcase
        end
    end

    // user store: bit 5 of the address picks the block
    always_ff @(posedge mclk) begin
        if (wr_sdata && flash_ok) store[st_addr] <= wdata[7:0];
    end

    // reset counters, one byte per reset type; snapshot on query
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_cnt <= 32'h0000_0000;
            rst_snap <= 32'h0000_0000;
        end else begin
            if (cmd_reset)
                rst_cnt[rtype*8 +: 8] <= rst_cnt[rtype*8 +: 8]
                    + 8'h01;
            if (cmd_query) rst_snap <= rst_cnt;
        end
    end

    // offset calibration: start, finish, or abort on a load step
    always_ff @(posedge mclk) begin
        if (rst) begin
            cal_busy <= 1'b0;
            cal_start <= 1'b0;
            cal_v0 <= 16'h0000;
            last_v <= 16'h0000;
            last_t <= 8'sh00;
            offset <= 16'sh0000;
        end else begin
            cal_start <= cal_go;
            if (cal_go) begin
                cal_busy <= 1'b1;
                cal_v0 <= cell_mv;
            end else if (abort) begin
                cal_busy <= 1'b0;
            end else if (cal_busy && cal_done) begin
                cal_busy <= 1'b0;
                offset <= cal_offset;
                last_v <= cell_mv;
                last_t <= temp_c;
            end
        end
    end

    // temperature drift persistence; any return restarts it
    always_ff @(posedge mclk) begin
        if (rst || !t_dev) begin
            drift_cnt <= 32'h0000_0000;
        end else if (!t_long) begin
            drift_cnt <= drift_cnt + 32'h0000_0001;
        end
    end

    // offset correction and charge integration; held rate while busy
    always_ff @(posedge mclk) begin
        if (rst) begin
            sense_corr <= 16'sh0000;
            charge <= 32'sh0000_0000;
        end else if (meas_valid) begin
            if (!cal_busy) begin
                sense_corr <= sense_uv - offset;
                charge <= charge + 32'(sense_uv - offset);
            end else begin
                charge <= charge + 32'(sense_corr);
            end
        end
    end

    // sticky status: a new event beats a same-cycle clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((wr && addr == gwoc_pkg::A_ICLR)
                ? wdata[3:0] : 4'h0)) | events;
            irq <= |(irq_stat & irq_en);
        end
    end

    // read selection
    always_comb begin
        case (addr)
            gwoc_pkg::A_CTRL: next_rdata = {29'h0, ctrl};
            gwoc_pkg::A_STAT: next_rdata = {28'h0, wif.armed,
                cal_busy, pm};
            gwoc_pkg::A_FMIN: next_rdata = {16'h0000, flash_min};
            gwoc_pkg::A_ISTAT: next_rdata = {28'h0, irq_stat};
            gwoc_pkg::A_IEN: next_rdata = {28'h0, irq_en};
            gwoc_pkg::A_RDATA: next_rdata = rst_snap;
            gwoc_pkg::A_SADDR: next_rdata = {26'h0, st_addr};
            gwoc_pkg::A_SDATA: next_rdata = {24'h0, store[st_addr]};
            gwoc_pkg::A_OFFS: next_rdata = 32'(offset);
            gwoc_pkg::A_CORR: next_rdata = 32'(sense_corr);
            gwoc_pkg::A_CHG: next_rdata = charge;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? next_rdata : 32'h0000_0000;
        end
    end

    assign power_mode = pm;

    property p_refuse;
        @(posedge mclk) disable iff (rst)
        (wr_sdata && cell_mv < flash_min) |=> irq_stat[gwoc_pkg::IRQ_REFUSE];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("low voltage store write not flagged");

    property p_cal_idle;
        @(posedge mclk) disable iff (rst)
        (pm == gwoc_pkg::PM_NORMAL && cmd_idle && !cmd_reset && !cal_busy
            && temp_c > 8'sd5 && temp_c < 8'sd45) |=> cal_start && cal_busy;
    endproperty
    a_cal_idle: assert property (p_cal_idle)
        else $error("idle entry did not start calibration");

    property p_corr;
        @(posedge mclk) disable iff (rst)
        (meas_valid && !cal_busy) |=>
            sense_corr == $past(sense_uv) - $past(offset);
    endproperty
    a_corr: assert property (p_corr)
        else $error("offset not removed from sense sample");

    property p_hold;
        @(posedge mclk) disable iff (rst)
        (meas_valid && cal_busy) |=>
            charge == $past(charge) + 32'($past(sense_corr))
            && $stable(sense_corr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("charge not advanced at held rate");

    property p_abort;
        @(posedge mclk) disable iff (rst)
        (cal_busy && meas_valid && cell_mv + 16'd33 <= cal_v0) |=>
            !cal_busy ##1 irq_stat[gwoc_pkg::IRQ_ABRT];
    endproperty
    a_abort: assert property (p_abort)
        else $error("calibration not aborted on voltage drop");

    property p_rcount;
        @(posedge mclk) disable iff (rst)
        (cmd_reset && rtype == 2'd0) |=>
            rst_cnt[7:0] == $past(rst_cnt[7:0]) + 8'h01;
    endproperty
    a_rcount: assert property (p_rcount)
        else $error("reset counter not incremented");

    property p_drift;
        @(posedge mclk) disable iff (rst)
        !t_dev |=> drift_cnt == 32'h0000_0000;
    endproperty
    a_drift: assert property (p_drift)
        else $error("drift timer not restarted");

    property p_wakeup;
        @(posedge mclk) disable iff (rst)
        (wif.wake && pm == gwoc_pkg::PM_IDLE) |=>
            power_mode == gwoc_pkg::PM_NORMAL;
    endproperty
    a_wakeup: assert property (p_wakeup)
        else $error("wake did not return to normal");

    property p_irq;
        @(posedge mclk) disable iff (rst)
        (events != 4'h0 && (events & irq_en) != 4'h0 && !wr)
            |-> ##2 irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled event did not raise interrupt");
endmodule: gwoc_top

// >>> hdl/gwoc_wake.sv
// sleep current wake comparator with selectable threshold
`timescale 1ns/10ps
module gwoc_wake (
    input wire logic mclk, // core clock
    input wire logic rst, // synchronous reset
    gwoc_wake_if.cmp w // configuration, sense and wake
);
    // threshold from {range, hi, lo}; zero means disabled
    function automatic logic [15:0] thr(input logic [2:0] c);
        case (c)
            3'b001: thr = gwoc_pkg::THR_1;
            3'b101, 3'b010: thr = gwoc_pkg::THR_2;
            3'b110, 3'b011: thr = gwoc_pkg::THR_4;
            3'b111: thr = gwoc_pkg::THR_9;
            default: thr = 16'h0000;
        endcase
    endfunction: thr

    // selection and two-sided compare
    wire logic [15:0] th = thr({w.range_sel, w.sel_hi, w.sel_lo});
    wire logic enabled = w.sel_hi | w.sel_lo;
    wire logic signed [16:0] s17 = 17'(w.sense_uv);
    wire logic signed [16:0] t17 = $signed({1'b0, th});
    wire logic over = (s17 > t17) || (s17 < -t17);
    wire logic next_wake = w.armed & enabled & over;

    // registered so the core sees a clean level
    always_ff @(posedge mclk) begin
        if (rst) begin
            w.wake <= 1'b0;
        end else begin
            w.wake <= next_wake;
        end
    end

    property p_wake_off;
        @(posedge mclk) disable iff (rst)
        (!w.sel_hi && !w.sel_lo) |=> !w.wake;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake raised while comparator disabled");

    property p_wake_thr;
        @(posedge mclk) disable iff (rst)
        (w.armed && w.range_sel && w.sel_hi && w.sel_lo
            && w.sense_uv < -16'sd9800) |=> w.wake;
    endproperty
    a_wake_thr: assert property (p_wake_thr)
        else $error("no wake beyond top discharge threshold");
endmodule: gwoc_wake

// >>> tb/gwoc_afe_model.sv
// offset measurement front end answering calibration starts
`timescale 1ns/10ps
module gwoc_afe_model (
    input wire logic mclk, // core clock
    input wire logic rst, // synchronous reset
    input wire logic cal_start, // calibration start pulse
    input wire logic [7:0] lat, // cycles until the answer
    input wire logic signed [15:0] offs, // offset to report
    output logic cal_done, // one cycle finished pulse
    output logic signed [15:0] cal_offset // valid only with cal_done
);
    logic busy;
    logic [7:0] cnt;
    // outside the done cycle the offset bus shows junk, not a held value
    assign cal_offset = cal_done ? offs : ~offs;
    // one measurement per start; a start while busy restarts it
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            cal_done <= 1'b0;
            cnt <= 8'h00;
        end else begin
            cal_done <= 1'b0;
            if (cal_start) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                cal_done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule: gwoc_afe_model

// >>> tb/test_gwoc_top.sv
// self-checking bench for the gauge wake and calibration block
`timescale 1ns/10ps
module test_gwoc_top;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, meas_valid = 1'b0;
    logic [7:0] addr = 8'h00, lat = 8'h03;
    logic [31:0] wdata = 32'h0000_0000, rdata, v, c0;
    logic signed [15:0] sense_uv = 16'h0000, mean_ma = 16'h00C8;
    logic signed [15:0] offs = 16'h0096, cal_offset, t;
    logic [15:0] cell_mv = 16'h0E10;
    logic signed [7:0] temp_c = 8'h32;
    logic cal_done, cal_start, irq;
    logic [1:0] power_mode;
    int fails = 0, comparisons = 0, ncal = 0, exp_cal;
    logic signed [15:0] thr [8] = '{16'h0000, 16'h0000, gwoc_pkg::THR_1,
        gwoc_pkg::THR_2, gwoc_pkg::THR_2, gwoc_pkg::THR_4,
        gwoc_pkg::THR_4, gwoc_pkg::THR_9};
    logic signed [7:0] temps [4] = '{8'h05, 8'h2D, 8'h2C, 8'h06};

    always #10 mclk = ~mclk;
    // count start pulses; a stuck-high start shows as a runaway count
    always @(posedge mclk) if (cal_start === 1'b1) ncal <= ncal + 1;

    gwoc_top #(.DRIFT_CYCLES(50), .DOZE_CYCLES(20)) gwoc_top_i (.mclk(mclk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .meas_valid(meas_valid), .sense_uv(sense_uv),
        .cell_mv(cell_mv), .temp_c(temp_c), .mean_ma(mean_ma),
        .cal_done(cal_done), .cal_offset(cal_offset),
        .cal_start(cal_start), .power_mode(power_mode), .irq(irq));
    gwoc_afe_model gwoc_afe_model_i (.mclk(mclk), .rst(rst),
        .cal_start(cal_start), .lat(lat), .offs(offs), .cal_done(cal_done),
        .cal_offset(cal_offset));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask: finish_test
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask: chk
    // one-cycle strobes, released at the following edge
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask: wreg
    task automatic rreg(input logic [7:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask: rreg
    task automatic rchk(input string nm, input logic [7:0] a, input int e);
        rreg(a);
        chk(nm, v, e);
    endtask: rchk
    task automatic cmd(input logic [7:0] sub, input logic [1:0] typ);
        wreg(gwoc_pkg::A_CMD, {22'h00_0000, typ, sub});
    endtask: cmd
    task automatic meas(input logic signed [15:0] s);
        @(posedge mclk);
        meas_valid <= 1'b1;
        sense_uv <= s;
        @(posedge mclk);
        meas_valid <= 1'b0;
    endtask: meas
    task automatic mode(input logic [1:0] e);
        repeat (2) @(posedge mclk);
        chk("power_mode", {30'h0, power_mode}, {30'h0, e});
    endtask: mode

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rchk("ctrl", gwoc_pkg::A_CTRL, 0);
        rchk("fmin", gwoc_pkg::A_FMIN, 32'h0000_0D48);
        rchk("unmapped", 8'h3C, 0);
        // host mode commands, then idle dozes into deep on its own
        cmd(gwoc_pkg::SC_DEEP, 2'h0); mode(gwoc_pkg::PM_DEEP);
        cmd(gwoc_pkg::SC_DORM, 2'h0); mode(gwoc_pkg::PM_DORM);
        cmd(gwoc_pkg::SC_WAKE, 2'h0); mode(gwoc_pkg::PM_NORMAL);
        cmd(gwoc_pkg::SC_IDLE, 2'h0); mode(gwoc_pkg::PM_IDLE);
        rchk("stat_mode", gwoc_pkg::A_STAT, 32'h0000_0009);
        repeat (25) @(posedge mclk);
        mode(gwoc_pkg::PM_DEEP);
        cmd(gwoc_pkg::SC_WAKE, 2'h0);
        // reset counters by type, snapshot on query
        cmd(gwoc_pkg::SC_RESET, 2'h2);
        cmd(gwoc_pkg::SC_RESET, 2'h2);
        cmd(gwoc_pkg::SC_RESET, 2'h0);
        cmd(gwoc_pkg::SC_RQUERY, 2'h0);
        rchk("rst_count", gwoc_pkg::A_RDATA, 32'h0002_0001);
        // store gating on flash minimum, two blocks, refusal interrupt
        wreg(gwoc_pkg::A_FMIN, 32'h0000_0DAC);
        wreg(gwoc_pkg::A_IEN, 32'h0000_0008);
        cell_mv <= 16'h0DAC;
        wreg(gwoc_pkg::A_SADDR, 32'h0000_0005);
        wreg(gwoc_pkg::A_SDATA, 32'h0000_005A);
        wreg(gwoc_pkg::A_SADDR, 32'h0000_0025);
        wreg(gwoc_pkg::A_SDATA, 32'h0000_003C);
        rchk("blk_b", gwoc_pkg::A_SDATA, 32'h0000_003C);
        wreg(gwoc_pkg::A_SADDR, 32'h0000_0005);
        rchk("blk_a", gwoc_pkg::A_SDATA, 32'h0000_005A);
        chk("irq_idle", irq, 1'b0);
        cell_mv <= 16'h0DAB;
        wreg(gwoc_pkg::A_SDATA, 32'h0000_00A5);
        rchk("refused", gwoc_pkg::A_SDATA, 32'h0000_005A);
        chk("irq_set", irq, 1'b1);
        wreg(gwoc_pkg::A_ICLR, 32'h0000_0008);
        rchk("istat_clr", gwoc_pkg::A_ISTAT, 0);
        chk("irq_clr", irq, 1'b0);
        wreg(gwoc_pkg::A_IEN, 32'h0000_0000);
        wreg(gwoc_pkg::A_SDATA, 32'h0000_00A5);
        rchk("istat_ref", gwoc_pkg::A_ISTAT, 32'h0000_0008);
        chk("irq_mask", irq, 1'b0);
        wreg(gwoc_pkg::A_ICLR, 32'h0000_000F);
        // idle entry calibration, offset correction and charge
        cell_mv <= 16'h0E10;
        temp_c <= 8'h14;
        cmd(gwoc_pkg::SC_IDLE, 2'h0);
        repeat (10) @(posedge mclk);
        chk("cal_idle", ncal, 1);
        rchk("offset", gwoc_pkg::A_OFFS, 32'h0000_0096);
        rchk("istat_cal", gwoc_pkg::A_ISTAT, 32'h0000_0002);
        wreg(gwoc_pkg::A_ICLR, 32'h0000_000F);
        cmd(gwoc_pkg::SC_WAKE, 2'h0);
        rreg(gwoc_pkg::A_CHG);
        c0 = v;
        meas(16'h03E8);
        rchk("corrected", gwoc_pkg::A_CORR, 32'h0000_0352);
        rreg(gwoc_pkg::A_CHG);
        chk("charge_step", v - c0, 32'h0000_0352);
        // voltage drift at low current: 255 mV no, 256 mV yes
        mean_ma <= 16'h0032;
        cell_mv <= 16'h0F0F;
        meas(16'h0000);
        repeat (5) @(posedge mclk);
        chk("drift_255", ncal, 1);
        cell_mv <= 16'h0F10;
        repeat (8) @(posedge mclk);
        chk("drift_256", ncal, 2);
        mean_ma <= 16'h00C8;
        repeat (8) @(posedge mclk);
        // temperature window for idle entry calibration
        exp_cal = 2;
        foreach (temps[i]) begin
            temp_c <= temps[i];
            cmd(gwoc_pkg::SC_IDLE, 2'h0);
            repeat (8) @(posedge mclk);
            cmd(gwoc_pkg::SC_WAKE, 2'h0);
            if (temps[i] > 8'sh05 && temps[i] < 8'sh2D) exp_cal++;
            chk("cal_temp", ncal, exp_cal);
        end
        // slow answer; 32 mV sag tolerated, 33 mV aborts
        // earlier calibrations left their done bit set
        wreg(gwoc_pkg::A_ICLR, 32'h0000_000F);
        lat <= 8'h64;
        offs <= 16'h00C8; // a late answer must not land
        temp_c <= 8'h14;
        cmd(gwoc_pkg::SC_IDLE, 2'h0);
        rreg(gwoc_pkg::A_STAT);
        chk("busy", v[2], 1'b1);
        cell_mv <= 16'h0EF0;
        meas(16'h0000);
        rchk("no_abort", gwoc_pkg::A_ISTAT, 0);
        cell_mv <= 16'h0EEF;
        meas(16'h0000);
        rchk("abort", gwoc_pkg::A_ISTAT, 32'h0000_0004);
        rreg(gwoc_pkg::A_STAT);
        chk("busy_off", v[2], 1'b0);
        repeat (110) @(posedge mclk);
        rchk("late_done", gwoc_pkg::A_OFFS, 32'h0000_0096);
        cmd(gwoc_pkg::SC_WAKE, 2'h0);
        wreg(gwoc_pkg::A_ICLR, 32'h0000_000F);
        // wake thresholds: at the level no event, one past it wakes
        temp_c <= 8'h32;
        for (int c = 0; c < 8; c++) begin
            sense_uv <= 16'sh0000; // no stale level from the last pass
            wreg(gwoc_pkg::A_CTRL, c);
            cmd(gwoc_pkg::SC_IDLE, 2'h0);
            t = c[0] ? -thr[c] : thr[c];
            if (thr[c] == 16'sh0000) meas(16'h7FFF);
            else meas(t);
            rreg(gwoc_pkg::A_ISTAT);
            chk("wake_edge", v[0], 1'b0);
            meas(c[0] ? t - 16'sh0001 : t + 16'sh0001);
            rreg(gwoc_pkg::A_ISTAT);
            chk("wake", v[0], thr[c] != 16'sh0000);
            wreg(gwoc_pkg::A_ICLR, 32'h0000_000F);
            cmd(gwoc_pkg::SC_WAKE, 2'h0);
        end
        finish_test();
    end
endmodule: test_gwoc_top
